// >>> rtl/transient_level_sequencer.sv
// transient level sequencer: steps the load setpoint between low and high levels
// assumes synchronous pins, a 40 MHz clock and a one-cycle-latency register port
`timescale 1ns/1ps
//Contract
// R1: while transient runs, a regulation mode write is refused.
// R2: continuous mode loops rise, high hold, fall, low hold forever.
// R3: pulsed mode with no trigger rests at low level.
// R4: pulsed trigger gives rise, high hold, fall, then low rest.
// R5: pulsed mode ignores the low hold time.
// R6: pulsed triggers count only while resting low; others dropped.
// R7: each accepted pulsed trigger yields exactly one pulse.
// R8: toggled mode rests low, first trigger ramps up and holds high.
// R9: toggled triggers reverse level using rise or fall ramp.
// R10: toggled mode ignores both hold times.
// R11: triggers from external pin, keys, bus message or commands.
// R12: pulsed and toggled start at low level when input switches on.
// R13: separate low and high levels per regulation mode.
// R14: sub-mode selector picks waveform and applicable timings.
// R15: input shut-off by threshold or current limit stops transient.
// R16: hold and ramp times are 16-bit counts of 10 us, to 655.35 ms.
// R17: transient only in current, voltage, resistance and not with list.
// R18: external trigger recognised on its falling edge.
// R19: times counted in 10 us ticks; ramps interpolate once per tick.
// R20: zero time steps at once yet passes each phase in order.
module transient_level_sequencer
#(
	parameter int TICK_CYC = tls_pkg::TICK_CYCLES
)
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        nrst,
	// register port
	input  wire logic [3:0]  regAddr,
	input  wire logic [31:0] regWdata,
	input  wire logic        regWr,
	input  wire logic        regRd,
	output logic [31:0]      regRdata,
	// trigger sources and load status
	input  wire logic        externalTriggerInput,
	input  wire logic        keyTrigger,
	input  wire logic        inputOn,
	input  wire logic        inputShutdown,
	input  wire logic        listActive,
	// regulation stage
	output logic [15:0]      setpoint,
	output logic [1:0]       regMode,
	output logic             transientActive
);

	// ************************************************************
	// register state
	// ************************************************************
	logic [31:0] ctrl,     next_ctrl;
	logic [15:0] lowHold,  next_lowHold;
	logic [15:0] highHold, next_highHold;
	logic [15:0] riseTime, next_riseTime;
	logic [15:0] fallTime, next_fallTime;
	logic [15:0] levels [6];
	logic [15:0] next_levels [6];
	logic        refused,  next_refused;
	logic        stopped,  next_stopped;
	logic [31:0] rdata,    next_rdata;
	logic        busTrig,  immTrig;

	logic [1:0]  subMode;
	logic [1:0]  curReg;
	logic        enBit;
	assign enBit   = ctrl[tls_pkg::CTRL_EN];
	assign subMode = ctrl[tls_pkg::CTRL_SUB_LO +: 2];
	assign curReg  = ctrl[tls_pkg::CTRL_REG_LO +: 2];

	// transient may only run in a valid regulation mode and not with list R17
	logic running;
	assign running = enBit && inputOn && !listActive && (curReg != 2'h3) && !stopped;

	function automatic logic isLevelAddr(input logic [3:0] a);
		isLevelAddr = (a >= tls_pkg::REG_LVL_BASE) && (a < tls_pkg::REG_LVL_BASE + 4'h6);
	endfunction : isLevelAddr

	tls_pkg::tls_state_t state, next_state;
	logic [15:0] holdCnt, next_holdCnt;
	logic        toggleHigh, next_toggleHigh;

	// ************************************************************
	// register write and readback
	// ************************************************************
	always_comb
	begin
		next_ctrl     = ctrl;
		next_lowHold  = lowHold;
		next_highHold = highHold;
		next_riseTime = riseTime;
		next_fallTime = fallTime;
		next_levels   = levels;
		next_refused  = refused;
		next_stopped  = stopped;
		next_rdata    = 32'h0000_0000;
		busTrig       = 1'b0;
		immTrig       = 1'b0;
		if (running && inputShutdown)
			next_stopped = 1'b1; // shut-off ends the test R15
		if (regWr)
		begin
			case (regAddr)
				tls_pkg::REG_CTRL:
				begin
					next_ctrl = regWdata & 32'h0000_00FF;
					if (enBit && regWdata[tls_pkg::CTRL_REG_LO +: 2] != curReg)
					begin
						next_ctrl[tls_pkg::CTRL_REG_LO +: 2] = curReg; // R1
						next_refused = 1'b1;
					end
					if (!regWdata[tls_pkg::CTRL_EN])
						next_stopped = 1'b0;
				end
				tls_pkg::REG_CMD:
				begin
					busTrig = regWdata[tls_pkg::CMD_BUSTRIG] && ctrl[tls_pkg::CTRL_BUS_EN];
					immTrig = regWdata[tls_pkg::CMD_IMMTRIG];
				end
				tls_pkg::REG_STATUS:
				begin
					if (regWdata[tls_pkg::STAT_REFUSED])
						next_refused = 1'b0;
				end
				tls_pkg::REG_LOWHOLD:  next_lowHold  = regWdata[15:0]; // R16
				tls_pkg::REG_HIGHHOLD: next_highHold = regWdata[15:0];
				tls_pkg::REG_RISE:     next_riseTime = regWdata[15:0];
				tls_pkg::REG_FALL:     next_fallTime = regWdata[15:0];
				default:
				begin
					if (isLevelAddr(regAddr))
						next_levels[3'(regAddr - tls_pkg::REG_LVL_BASE)] = regWdata[15:0]; // R13
				end
			endcase
		end
		if (regRd)
		begin
			case (regAddr)
				tls_pkg::REG_CTRL:     next_rdata = ctrl;
				tls_pkg::REG_STATUS:   next_rdata = {26'h0, stopped, refused, 4'h0} | {27'h0, state};
				tls_pkg::REG_LOWHOLD:  next_rdata = {16'h0, lowHold};
				tls_pkg::REG_HIGHHOLD: next_rdata = {16'h0, highHold};
				tls_pkg::REG_RISE:     next_rdata = {16'h0, riseTime};
				tls_pkg::REG_FALL:     next_rdata = {16'h0, fallTime};
				tls_pkg::REG_SETPT:    next_rdata = {16'h0, setpoint};
				default:
				begin
					if (isLevelAddr(regAddr))
						next_rdata = {16'h0, levels[3'(regAddr - tls_pkg::REG_LVL_BASE)]};
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			ctrl     <= tls_pkg::CTRL_RESET;
			lowHold  <= 16'h0000;
			highHold <= 16'h0000;
			riseTime <= 16'h0001;
			fallTime <= 16'h0001;
			for (int i = 0; i < 6; i++)
				levels[i] <= 16'h0000;
			refused  <= 1'b0;
			stopped  <= 1'b0;
			rdata    <= 32'h0000_0000;
		end
		else
		begin
			ctrl     <= next_ctrl;
			lowHold  <= next_lowHold;
			highHold <= next_highHold;
			riseTime <= next_riseTime;
			fallTime <= next_fallTime;
			levels   <= next_levels;
			refused  <= next_refused;
			stopped  <= next_stopped;
			rdata    <= next_rdata;
		end
	end

	// ************************************************************
	// tick generator and trigger gathering
	// ************************************************************
	logic [15:0] tickCnt, next_tickCnt;
	logic        tickPulse;
	logic        extPrev;
	logic        trigger;
	assign tickPulse    = (tickCnt == 16'(TICK_CYC - 1));
	assign next_tickCnt = tickPulse ? 16'h0000 : tickCnt + 16'h0001;
	// falling edge on the pin, keys, bus and commands all trigger R11
	assign trigger = (extPrev && !externalTriggerInput && ctrl[tls_pkg::CTRL_EXT_EN]) // R18
		|| (keyTrigger && ctrl[tls_pkg::CTRL_KEY_EN]) || busTrig || immTrig;

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			tickCnt <= 16'h0000;
			extPrev <= 1'b1;
		end
		else
		begin
			tickCnt <= next_tickCnt;
			extPrev <= externalTriggerInput;
		end
	end

	// ************************************************************
	// sequencer state machine
	// ************************************************************
	logic [15:0]        lowLvl, highLvl, rampValue;
	logic               rampDone;
	tls_pkg::tls_ramp_t rampReq;
	assign lowLvl  = levels[{curReg, 1'b0}];  // level pair of active mode R13
	assign highLvl = levels[{curReg, 1'b1}];

	always_comb
	begin
		next_state      = state;
		next_holdCnt    = holdCnt;
		next_toggleHigh = toggleHigh;
		rampReq         = '0;
		if (!running)
		begin
			next_state      = tls_pkg::TLS_IDLE; // restart from low R12
			next_toggleHigh = 1'b0;
		end
		else
		begin
			case (state)
				tls_pkg::TLS_IDLE:
				begin
					// continuous runs freely; pulse waits low R14 R3
					if (subMode == tls_pkg::TLS_SUB_CONT
						|| (trigger && subMode == tls_pkg::TLS_SUB_PULSE) // R6 R7
						|| (trigger && subMode == tls_pkg::TLS_SUB_TOGGLE && !toggleHigh)) // R8
					begin
						next_state = tls_pkg::TLS_RISE;
						rampReq    = '{1'b1, riseTime, lowLvl, highLvl}; // R4
					end
					else if (trigger && subMode == tls_pkg::TLS_SUB_TOGGLE)
					begin
						next_state = tls_pkg::TLS_FALL;
						rampReq    = '{1'b1, fallTime, highLvl, lowLvl}; // R9
					end
				end
				tls_pkg::TLS_RISE:
				begin
					if (rampDone)
					begin
						next_holdCnt = 16'h0000;
						next_state   = tls_pkg::TLS_HIGH;
						if (subMode == tls_pkg::TLS_SUB_TOGGLE)
						begin
							next_toggleHigh = 1'b1; // hold ignored R10
							next_state      = tls_pkg::TLS_IDLE;
						end
					end
				end
				tls_pkg::TLS_HIGH:
				begin
					if (holdCnt >= highHold) // zero hold still visits phase R20
					begin
						next_state = tls_pkg::TLS_FALL;
						rampReq    = '{1'b1, fallTime, highLvl, lowLvl};
					end
					else if (tickPulse)
						next_holdCnt = holdCnt + 16'h0001;
				end
				tls_pkg::TLS_FALL:
				begin
					if (rampDone)
					begin
						next_holdCnt    = 16'h0000;
						next_toggleHigh = 1'b0;
						// low hold only in continuous mode R5 R10
						next_state = (subMode == tls_pkg::TLS_SUB_CONT) ?
							tls_pkg::TLS_LOW : tls_pkg::TLS_IDLE;
					end
				end
				tls_pkg::TLS_LOW:
				begin
					if (holdCnt >= lowHold)
					begin
						next_state = tls_pkg::TLS_RISE; // loop forever R2
						rampReq    = '{1'b1, riseTime, lowLvl, highLvl};
					end
					else if (tickPulse)
						next_holdCnt = holdCnt + 16'h0001;
				end
				default: next_state = tls_pkg::TLS_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			state      <= tls_pkg::TLS_IDLE;
			holdCnt    <= 16'h0000;
			toggleHigh <= 1'b0;
		end
		else
		begin
			state      <= next_state;
			holdCnt    <= next_holdCnt;
			toggleHigh <= next_toggleHigh;
		end
	end

	tls_ramp u_ramp
	(
		.clk       (clk),
		.nrst      (nrst),
		.tickPulse (tickPulse),
		.req       (rampReq),
		.value     (rampValue),
		.done      (rampDone)
	);

	// ************************************************************
	// output registers
	// ************************************************************
	logic [15:0] next_setpoint;
	always_comb
	begin
		if (state == tls_pkg::TLS_RISE || state == tls_pkg::TLS_FALL)
			next_setpoint = rampValue;
		else if (state == tls_pkg::TLS_HIGH || (state == tls_pkg::TLS_IDLE && toggleHigh))
			next_setpoint = highLvl;
		else
			next_setpoint = lowLvl; // rest at low R3
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			setpoint        <= 16'h0000;
			regMode         <= 2'h0;
			transientActive <= 1'b0;
			regRdata        <= 32'h0000_0000;
		end
		else
		begin
			setpoint        <= next_setpoint;
			regMode         <= curReg;
			transientActive <= running;
			regRdata        <= next_rdata;
		end
	end

	a_mode_locked: assert property (@(posedge clk) disable iff (!nrst) // R1
		(regWr && regAddr == tls_pkg::REG_CTRL && enBit) |=>
		ctrl[tls_pkg::CTRL_REG_LO +: 2] == $past(curReg))
		else $error("regulation mode changed during transient");
	a_pulse_ignore: assert property (@(posedge clk) disable iff (!nrst) // R6
		(state == tls_pkg::TLS_HIGH && subMode == tls_pkg::TLS_SUB_PULSE && running)
		|=> state != tls_pkg::TLS_RISE)
		else $error("pulse retriggered while high");
	a_shutdown_stop: assert property (@(posedge clk) disable iff (!nrst) // R15
		(running && inputShutdown) |=> ##1 !transientActive)
		else $error("transient kept running after shutdown");
	a_cont_low: assert property (@(posedge clk) disable iff (!nrst) // R5
		(state == tls_pkg::TLS_LOW) |-> subMode == tls_pkg::TLS_SUB_CONT)
		else $error("low hold used outside continuous");
	a_rest_low: assert property (@(posedge clk) disable iff (!nrst) // R3
		(state == tls_pkg::TLS_IDLE && !toggleHigh) |=> setpoint == $past(lowLvl))
		else $error("setpoint left low level while resting");

endmodule : transient_level_sequencer

// >>> rtl/tls_pkg.sv
// transient level sequencer package: register map, fields, states, timing
// assumes a single 40 MHz system clock and a simple strobe register port
package tls_pkg;

	// ************************************************************
	// register offsets (word index on the plain register port)
	// ************************************************************
	localparam logic [3:0] REG_CTRL     = 4'h0; // enable, sub-mode, reg mode, pin/key/bus trigger source enables
	localparam logic [3:0] REG_CMD      = 4'h1; // bus trigger / immediate trigger pulses
	localparam logic [3:0] REG_STATUS   = 4'h2; // phase, refused mode changes, stop flag
	localparam logic [3:0] REG_LOWHOLD  = 4'h3;
	localparam logic [3:0] REG_HIGHHOLD = 4'h4;
	localparam logic [3:0] REG_RISE     = 4'h5;
	localparam logic [3:0] REG_FALL     = 4'h6;
	localparam logic [3:0] REG_SETPT    = 4'h7;
	localparam logic [3:0] REG_LVL_BASE = 4'h8; // 8..13: low/high pair per reg mode

	// ************************************************************
	// control field positions
	// ************************************************************
	localparam int CTRL_EN      = 0;
	localparam int CTRL_SUB_LO  = 1; // 2 bits sub-mode
	localparam int CTRL_REG_LO  = 3; // 2 bits regulation mode
	localparam int CTRL_EXT_EN  = 5;
	localparam int CTRL_KEY_EN  = 6;
	localparam int CTRL_BUS_EN  = 7;
	localparam int CMD_BUSTRIG  = 0; // bus get message or common trigger
	localparam int CMD_IMMTRIG  = 1; // subsystem trigger, always honoured
	localparam int STAT_REFUSED = 4;
	localparam int STAT_STOPPED = 5;

	localparam logic [31:0] CTRL_RESET = 32'h0000_00E0;

	// ************************************************************
	// timing: one tick is 10 us
	// ************************************************************
	localparam int TICK_NS     = 10000;
	localparam int CLK_NS      = 25;
	localparam int TICK_CYCLES = TICK_NS / CLK_NS;

	typedef enum logic [1:0] {
		TLS_SUB_CONT   = 2'h0,
		TLS_SUB_PULSE  = 2'h1,
		TLS_SUB_TOGGLE = 2'h2
	} tls_sub_t;

	typedef enum logic [1:0] {
		TLS_REG_CURR = 2'h0,
		TLS_REG_VOLT = 2'h1,
		TLS_REG_RES  = 2'h2
	} tls_reg_t;

	typedef enum logic [4:0] {
		TLS_IDLE = 5'h01,
		TLS_RISE = 5'h02,
		TLS_HIGH = 5'h04,
		TLS_FALL = 5'h08,
		TLS_LOW  = 5'h10
	} tls_state_t;

	// ramp request carried to the ramp engine
	typedef struct packed {
		logic        start;
		logic [15:0] ticks;
		logic [15:0] from;
		logic [15:0] to;
	} tls_ramp_t;

endpackage : tls_pkg

// >>> rtl/tls_ramp.sv
// linear ramp engine: interpolates setpoint once per 10 us tick
// assumes tickPulse is one cycle wide and start is a one-cycle request
`timescale 1ns/1ps
module tls_ramp
(
	// clock and reset
	input  wire logic            clk,
	input  wire logic            nrst,
	// control
	input  wire logic            tickPulse,
	input  wire tls_pkg::tls_ramp_t req,
	// results
	output logic [15:0]          value,
	output logic                 done
);

	logic [15:0] cnt,      next_cnt;
	logic [15:0] value_r,  next_value;
	logic [15:0] fromV,    next_fromV;
	logic [15:0] toV,      next_toV;
	logic [15:0] total,    next_total;
	logic        active,   next_active;
	logic        done_r,   next_done;
	logic signed [33:0] span;

	// ************************************************************
	// next-value logic: value = from + (to-from)*cnt/total
	// ************************************************************
	always_comb
	begin
		next_cnt    = cnt;
		next_value  = value_r;
		next_fromV  = fromV;
		next_toV    = toV;
		next_total  = total;
		next_active = active;
		next_done   = 1'b0;
		span        = '0;
		if (req.start)
		begin
			next_fromV  = req.from;
			next_toV    = req.to;
			next_total  = req.ticks;
			next_cnt    = 16'h0000;
			next_value  = req.from;
			next_active = (req.ticks != 16'h0000);
			if (req.ticks == 16'h0000)
			begin
				next_value = req.to; // zero time is an immediate step R20
				next_done  = 1'b1;
			end
		end
		else if (active && tickPulse)
		begin
			next_cnt = cnt + 16'h0001; // one step per tick R19
			span = (34'(signed'({1'b0, toV})) - 34'(signed'({1'b0, fromV})))
				* 34'(signed'({1'b0, next_cnt}));
			next_value = 16'(34'(signed'({1'b0, fromV})) + span / 34'(signed'({1'b0, total})));
			if (next_cnt == total)
			begin
				next_value  = toV;
				next_active = 1'b0;
				next_done   = 1'b1;
			end
		end
	end

	// ************************************************************
	// registers
	// ************************************************************
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			cnt     <= 16'h0000;
			value_r <= 16'h0000;
			fromV   <= 16'h0000;
			toV     <= 16'h0000;
			total   <= 16'h0000;
			active  <= 1'b0;
			done_r  <= 1'b0;
		end
		else
		begin
			cnt     <= next_cnt;
			value_r <= next_value;
			fromV   <= next_fromV;
			toV     <= next_toV;
			total   <= next_total;
			active  <= next_active;
			done_r  <= next_done;
		end
	end

	assign value = value_r;
	assign done  = done_r;

	a_ramp_end: assert property (@(posedge clk) disable iff (!nrst) // R19
		done |-> value == toV)
		else $error("ramp ended away from target");

endmodule : tls_ramp

// >>> testbench/tls_load_model.sv
// far side model: external trigger source and regulation stage monitor
// assumes setpoint is registered on clk and the trigger pin idles high
`timescale 1ns/1ps
module tls_load_model
(
	// clock
	input  wire logic        clk,
	// regulation stage
	input  wire logic [15:0] setpoint,
	input  wire logic [15:0] highLevel,
	output int               highCount,
	// trigger pin
	output logic             externalTriggerInput
);
	logic atHigh;

	// idle pin is high so only a deliberate pulse gives a falling edge
	initial
	begin
		highCount = 0;
		atHigh = 1'b0;
		externalTriggerInput = 1'b1;
	end

	// count each entry into the high level seen by the regulation stage
	always @(posedge clk)
	begin
		if (setpoint === highLevel && !atHigh)
			highCount <= highCount + 1;
		atHigh <= (setpoint === highLevel);
	end

	// logic level pulse, its falling edge is the trigger
	task automatic fire;
		@(posedge clk);
		externalTriggerInput <= 1'b0;
		repeat (3) @(posedge clk);
		externalTriggerInput <= 1'b1;
	endtask : fire
endmodule : tls_load_model

// >>> testbench/tb_transient_level_sequencer.sv
// self-checking bench for the transient level sequencer
// assumes the design package is compiled first and a 4 cycle tick
`timescale 1ns/1ps
`define CHK(act, exp) begin testsRun++; if ((act) !== (exp)) begin nErrors++; \
	$display("wrong value at %0t: got %h expected %h", $time, act, exp); end end
module tb_transient_level_sequencer;
	localparam logic [15:0] LC = 16'h0100;
	localparam logic [15:0] HC = 16'h0200;
	localparam logic [15:0] VL = 16'h0300;
	localparam logic [15:0] VH = 16'h0400;
	logic        clk;
	logic        nrst;
	logic [3:0]  regAddr;
	logic [31:0] regWdata;
	logic        regWr;
	logic        regRd;
	logic [31:0] regRdata;
	logic        externalTriggerInput;
	logic        keyTrigger;
	logic        inputOn;
	logic        inputShutdown;
	logic        listActive;
	logic [15:0] setpoint;
	logic [1:0]  regMode;
	logic        transientActive;
	logic [15:0] highLevel;
	int          highCount;
	int          nErrors;
	int          testsRun;
	logic [31:0] rd;

	// ************************************************************
	// design, far side model, clock
	// ************************************************************
	transient_level_sequencer #(.TICK_CYC(4)) u_dut (.clk(clk), .nrst(nrst),
		.regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
		.regRdata(regRdata), .externalTriggerInput(externalTriggerInput),
		.keyTrigger(keyTrigger), .inputOn(inputOn), .inputShutdown(inputShutdown),
		.listActive(listActive), .setpoint(setpoint), .regMode(regMode),
		.transientActive(transientActive));
	tls_load_model u_model (.clk(clk), .setpoint(setpoint), .highLevel(highLevel),
		.highCount(highCount), .externalTriggerInput(externalTriggerInput));

	// 40 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// ************************************************************
	// bus and stimulus tasks
	// ************************************************************
	task automatic regWrite(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge clk);
		regWr <= 1'b0;
	endtask : regWrite

	// read data stand only in the cycle after the strobe
	task automatic regRead(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge clk);
		regRd <= 1'b0;
		#1 d = regRdata;
	endtask : regRead

	function automatic logic [31:0] ctrl(input int sub, input int rm, input int en);
		return 32'h0000_00E0 | en | (sub << 1) | (rm << 3);
	endfunction : ctrl

	// trigger from one of four sources
	task automatic fire(input int src);
		case (src)
			0: u_model.fire();
			1:
			begin
				@(posedge clk);
				keyTrigger <= 1'b1;
				@(posedge clk);
				keyTrigger <= 1'b0;
			end
			2: regWrite(tls_pkg::REG_CMD, 32'h0000_0001);
			default: regWrite(tls_pkg::REG_CMD, 32'h0000_0002);
		endcase
	endtask : fire

	task automatic waitLevel(input logic [15:0] v);
		int n;
		n = 0;
		while (setpoint !== v && n < 300)
		begin
			@(posedge clk);
			#1 n++;
		end
		`CHK(setpoint, v)
	endtask : waitLevel

	task automatic stayAt(input logic [15:0] v, input int n);
		logic bad;
		bad = 1'b0;
		repeat (n)
		begin
			@(posedge clk);
			#1 if (setpoint !== v) bad = 1'b1;
		end
		`CHK(bad, 1'b0)
	endtask : stayAt

	// ************************************************************
	// scenarios
	// ************************************************************
	task automatic testReset;
		regRead(tls_pkg::REG_CTRL, rd);
		`CHK(rd, tls_pkg::CTRL_RESET)
		regRead(tls_pkg::REG_RISE, rd);
		`CHK(rd[15:0], 16'h0001)
		regWrite(4'h8, {16'h0000, LC});
		regWrite(4'h9, {16'h0000, HC});
		regWrite(4'hA, {16'h0000, VL});
		regWrite(4'hB, {16'h0000, VH});
		regRead(4'hB, rd);
		`CHK(rd[15:0], VH)
		regRead(4'hF, rd);
		`CHK(rd, 32'h0000_0000)
	endtask : testReset

	task automatic testContinuous;
		regWrite(tls_pkg::REG_LOWHOLD, 32'h0000_0002);
		regWrite(tls_pkg::REG_HIGHHOLD, 32'h0000_0002);
		regWrite(tls_pkg::REG_RISE, 32'h0000_0002);
		regWrite(tls_pkg::REG_FALL, 32'h0000_0001);
		regWrite(tls_pkg::REG_CTRL, ctrl(0, 0, 1));
		waitLevel(16'h0180);
		waitLevel(HC);
		waitLevel(LC);
		waitLevel(HC);
		`CHK(transientActive, 1'b1)
		regWrite(tls_pkg::REG_CTRL, ctrl(0, 0, 0));
	endtask : testContinuous

	// low hold of zero would restart pulses if it were used
	task automatic testPulse;
		int c;
		regWrite(tls_pkg::REG_LOWHOLD, 32'h0000_0000);
		regWrite(tls_pkg::REG_HIGHHOLD, 32'h0000_0003);
		regWrite(tls_pkg::REG_CTRL, ctrl(1, 0, 1));
		waitLevel(LC);
		stayAt(LC, 60);
		for (int s = 0; s < 4; s++)
		begin
			c = highCount;
			fire(s);
			waitLevel(HC);
			fire(1);
			waitLevel(LC);
			stayAt(LC, 60);
			`CHK(highCount, c + 1)
		end
		regWrite(tls_pkg::REG_CTRL, ctrl(1, 0, 0));
	endtask : testPulse

	task automatic testToggle;
		regWrite(tls_pkg::REG_LOWHOLD, 32'h0000_0001);
		regWrite(tls_pkg::REG_HIGHHOLD, 32'h0000_0001);
		regWrite(tls_pkg::REG_CTRL, ctrl(2, 0, 1));
		waitLevel(LC);
		stayAt(LC, 40);
		fire(0);
		waitLevel(HC);
		stayAt(HC, 60);
		regWrite(tls_pkg::REG_CTRL, ctrl(2, 1, 1));
		`CHK(regMode, 2'h0)
		regRead(tls_pkg::REG_STATUS, rd);
		`CHK(rd[4], 1'b1)
		regWrite(tls_pkg::REG_STATUS, 32'h0000_0010);
		regRead(tls_pkg::REG_STATUS, rd);
		`CHK(rd[4], 1'b0)
		fire(2);
		waitLevel(LC);
		stayAt(LC, 40);
		regWrite(tls_pkg::REG_CTRL, ctrl(2, 0, 0));
	endtask : testToggle

	task automatic testVolt;
		highLevel = VH;
		regWrite(tls_pkg::REG_CTRL, ctrl(1, 1, 0));
		regWrite(tls_pkg::REG_CTRL, ctrl(1, 1, 1));
		waitLevel(VL);
		`CHK(regMode, 2'h1)
		fire(3);
		waitLevel(VH);
		waitLevel(VL);
		regWrite(tls_pkg::REG_CTRL, ctrl(1, 1, 0));
		highLevel = HC;
	endtask : testVolt

	task automatic testStops;
		regWrite(tls_pkg::REG_CTRL, ctrl(0, 0, 0));
		regWrite(tls_pkg::REG_CTRL, ctrl(0, 0, 1));
		waitLevel(HC);
		inputShutdown <= 1'b1;
		repeat (4) @(posedge clk);
		`CHK(transientActive, 1'b0)
		regRead(tls_pkg::REG_STATUS, rd);
		`CHK(rd[5], 1'b1)
		inputShutdown <= 1'b0;
		regWrite(tls_pkg::REG_CTRL, ctrl(0, 0, 0));
		regRead(tls_pkg::REG_STATUS, rd);
		`CHK(rd[5], 1'b0)
		listActive <= 1'b1;
		regWrite(tls_pkg::REG_CTRL, ctrl(0, 0, 1));
		repeat (5) @(posedge clk);
		`CHK(transientActive, 1'b0)
		regWrite(tls_pkg::REG_CTRL, ctrl(0, 0, 0));
		listActive <= 1'b0;
		// switching the input off and on again restarts toggling from low
		regWrite(tls_pkg::REG_CTRL, ctrl(2, 0, 1));
		fire(0);
		waitLevel(HC);
		inputOn <= 1'b0;
		repeat (3) @(posedge clk);
		`CHK(transientActive, 1'b0)
		inputOn <= 1'b1;
		waitLevel(LC);
		stayAt(LC, 20);
		regWrite(tls_pkg::REG_CTRL, ctrl(2, 0, 0));
	endtask : testStops

	// ************************************************************
	// verdict, watchdog, main sequence
	// ************************************************************
	task automatic wrapUp;
		$display("checks %0d, mismatches %0d", testsRun, nErrors);
		if (nErrors == 0 && testsRun > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : wrapUp

	// whole run needs well under 20000 cycles
	initial
	begin
		#(25 * 60000);
		nErrors++;
		wrapUp();
	end

	initial
	begin
		nErrors = 0;
		testsRun = 0;
		nrst = 1'b0;
		regAddr = 4'h0;
		regWdata = 32'h0000_0000;
		regWr = 1'b0;
		regRd = 1'b0;
		keyTrigger = 1'b0;
		inputOn = 1'b1;
		inputShutdown = 1'b0;
		listActive = 1'b0;
		highLevel = HC;
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		testReset();
		testContinuous();
		testPulse();
		testToggle();
		testVolt();
		testStops();
		wrapUp();
	end
endmodule : tb_transient_level_sequencer
